//--- verilog/scfc_defs.vh
`ifndef SCFC_DEFS_VH
`define SCFC_DEFS_VH
`define SCFC_ADDR_W 12
`define SCFC_REG_CTRL 12'h000
`define SCFC_REG_STAT 12'h004
`define SCFC_REG_FAULT 12'h008
`define SCFC_REG_CFG 12'h00C
`define SCFC_REG_INTCFG 12'h010
`define SCFC_EN_PRE 0
`define SCFC_EN_CORE 1
`define SCFC_EN_ANA 2
`define SCFC_EN_AUX 3
`define SCFC_EN_XCV 4
`define SCFC_EN_RESET 5'h1F
`define SCFC_FLT_CORE_OV 0
`define SCFC_FLT_ANA_OV 1
`define SCFC_FLT_ANA_OC 2
`define SCFC_FLT_AUX_OV 3
`define SCFC_FLT_AUX_OC 4
`define SCFC_FLT_BATT 5
`define SCFC_SEL_BOTH_LOW 3'h0
`define SCFC_SEL_BOTH_HIGH 3'h1
`define SCFC_SEL_LOW_HIGH 3'h2
`define SCFC_SEL_HIGH_LOW 3'h3
`define SCFC_SEL_OPEN 3'h4
`define SCFC_SEL_GND 3'h5
`define SCFC_SEL_PRE 3'h6
`define SCFC_INT_LONG_US 100
`define SCFC_INT_SHORT_US 25
`define SCFC_CLK_MHZ 100
`define SCFC_INTCFG_RESET 2'h3
`endif

//--- verilog/scfc_supply_ctrl.v
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "scfc_defs.vh"
// Function
// - Detect buck or buck-boost pre-regulator from low-side gate pin on wake; the read after reset always gives buck.
// - All five regulators enabled after reset with no command.
// - Core, analog ref and auxiliary supplies switched on and off by command.
// - Core supply overvoltage disables the core supply.
// - Analog ref overvoltage disables it; overcurrent only with external pass transistor.
// - Auxiliary overcurrent or overvoltage disables it, records status, raises interrupt.
// - Core and analog ref diagnostics stored in status; each new event interrupts.
// - Strap sampled on low-power-off wake; the read after reset decodes the synchroniser reset value 0; held until next read.
// - Strap range selects one of four analog ref and auxiliary voltage pairs.
// - Open strap starts both analog ref and auxiliary at low setting.
// - Deep fail-safe enabled with strap to ground, disabled with strap to pre-regulator.
// - Deep fail-safe decoded separately by main and fail-safe logic each read.
// - New interrupt conditions in one cycle, or all those arriving during a pulse, give one low pulse on interrupt_pulse_n.
// - Interrupt behaviour and pulse length writable only during initialisation phase.
// - Decoded voltage settings readable through a status register.
// - Battery sense below threshold sets battery early warning flag.
// - Long interrupt pulse lasts at least 90 us, typically 100 us.
// - Short interrupt pulse lasts at least 20 us, typically 25 us.
module scfc_supply_ctrl #(
  parameter LONG_CYCLES = `SCFC_INT_LONG_US * `SCFC_CLK_MHZ,
  parameter SHORT_CYCLES = `SCFC_INT_SHORT_US * `SCFC_CLK_MHZ
) (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SCFC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire wake_low_power_off_state,
  input wire init_phase,
  input wire low_side_gate_pin,
  input wire [2:0] select_strap,
  input wire ext_pass_transistor,
  input wire core_ov,
  input wire ana_ov,
  input wire ana_oc,
  input wire aux_ov,
  input wire aux_oc,
  input wire battery_sense_low,
  output reg [4:0] reg_enable,
  output reg ana_high,
  output reg aux_high,
  output reg deep_fs_main,
  output reg deep_fs_safe,
  output reg buck_boost,
  output reg interrupt_pulse_n
);
  localparam CNT_W = 16;
  localparam CFG_IDLE = 2'h0;
  localparam CFG_WAIT = 2'h1;
  localparam CFG_READ = 2'h2;

  // Input synchronisers, first stage read only by second
  reg [10:0] s1_ff;
  reg [10:0] s2_ff;
  always @(posedge clk) begin
    if (reset) begin
      s1_ff <= 11'h000;
      s2_ff <= 11'h000;
    end else begin
      s1_ff <= {wake_low_power_off_state, low_side_gate_pin, select_strap, core_ov, ana_ov, ana_oc, aux_ov, aux_oc,
                battery_sense_low};
      s2_ff <= s1_ff;
    end
  end
  wire wake_s = s2_ff[10];
  wire gate_s = s2_ff[9];
  wire [2:0] strap_s = s2_ff[8:6];
  wire [5:0] ev_s = {s2_ff[0], s2_ff[1], s2_ff[2], s2_ff[3], s2_ff[4], s2_ff[5]};
  reg wake_d_ff;

  function [1:0] volt_pair;
    input [2:0] code;
    begin
      case (code)
        `SCFC_SEL_BOTH_HIGH: volt_pair = 2'h3;
        `SCFC_SEL_LOW_HIGH: volt_pair = 2'h1;
        `SCFC_SEL_HIGH_LOW: volt_pair = 2'h2;
        default: volt_pair = 2'h0;
      endcase
    end
  endfunction

  function deep_fs;
    input [2:0] code;
    begin
      case (code)
        `SCFC_SEL_GND: deep_fs = 1'b1;
        `SCFC_SEL_PRE: deep_fs = 1'b0;
        default: deep_fs = 1'b0;
      endcase
    end
  endfunction

  // Configuration read after reset and on wake from low-power off
  reg [1:0] cfg_state_ff;
  always @(posedge clk) begin
    if (reset) begin
      cfg_state_ff <= CFG_WAIT;
      wake_d_ff <= 1'b0;
      ana_high <= 1'b0;
      aux_high <= 1'b0;
      deep_fs_main <= 1'b0;
      buck_boost <= 1'b0;
    end else begin
      wake_d_ff <= wake_s;
      case (cfg_state_ff)
        CFG_IDLE: begin
          if (wake_s && !wake_d_ff) begin
            cfg_state_ff <= CFG_WAIT;
          end
        end
        CFG_WAIT: cfg_state_ff <= CFG_READ;
        CFG_READ: begin
          {ana_high, aux_high} <= volt_pair(strap_s);
          deep_fs_main <= deep_fs(strap_s);
          buck_boost <= gate_s;
          cfg_state_ff <= CFG_IDLE;
        end
        default: cfg_state_ff <= CFG_IDLE;
      endcase
    end
  end

  // Fail-safe side: own strap synchroniser, sequencer and decoder
  localparam FS_IDLE = 2'h0;
  localparam FS_WAIT = 2'h1;
  localparam FS_READ = 2'h2;
  reg [2:0] fs_strap_s1_ff;
  reg [2:0] fs_strap_s2_ff;
  reg fs_wake_s1_ff;
  reg fs_wake_s2_ff;
  reg fs_wake_d_ff;
  reg [1:0] fs_state_ff;

  function deep_fs_check;
    input [2:0] code;
    begin
      case (code)
        `SCFC_SEL_GND: deep_fs_check = 1'b1;
        `SCFC_SEL_PRE: deep_fs_check = 1'b0;
        default: deep_fs_check = 1'b0;
      endcase
    end
  endfunction

  always @(posedge clk) begin
    if (reset) begin
      fs_strap_s1_ff <= 3'h0;
      fs_strap_s2_ff <= 3'h0;
      fs_wake_s1_ff <= 1'b0;
      fs_wake_s2_ff <= 1'b0;
    end else begin
      fs_strap_s1_ff <= select_strap;
      fs_strap_s2_ff <= fs_strap_s1_ff;
      fs_wake_s1_ff <= wake_low_power_off_state;
      fs_wake_s2_ff <= fs_wake_s1_ff;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      fs_state_ff <= FS_WAIT;
      fs_wake_d_ff <= 1'b0;
      deep_fs_safe <= 1'b0;
    end else begin
      fs_wake_d_ff <= fs_wake_s2_ff;
      case (fs_state_ff)
        FS_IDLE: begin
          if (fs_wake_s2_ff && !fs_wake_d_ff)
            fs_state_ff <= FS_WAIT;
        end
        FS_WAIT: fs_state_ff <= FS_READ;
        FS_READ: begin
          deep_fs_safe <= deep_fs_check(fs_strap_s2_ff);
          fs_state_ff <= FS_IDLE;
        end
        default: fs_state_ff <= FS_IDLE;
      endcase
    end
  end

  // Fault event edges and sticky flags
  localparam NFLT = 6;
  reg [5:0] ev_d_ff;
  reg [5:0] fault_ff;
  integer fi;
  wire [5:0] ev_rise = ev_s & ~ev_d_ff;
  wire [5:0] ev_used = {ev_rise[5:3], ev_rise[2] & ext_pass_transistor, ev_rise[1:0]};
  wire acc = psel && penable;
  wire setup = psel && !penable;
  wire rd_fault = acc && !pwrite && (paddr == `SCFC_REG_FAULT);
  wire wr_ctrl = acc && pwrite && (paddr == `SCFC_REG_CTRL);
  wire wr_int = acc && pwrite && (paddr == `SCFC_REG_INTCFG) && init_phase;
  always @(posedge clk) begin
    if (reset) begin
      ev_d_ff <= 6'h00;
      fault_ff <= 6'h00;
    end else begin
      ev_d_ff <= ev_s;
      // A new event wins over a clearing read in the same cycle
      for (fi = 0; fi < NFLT; fi = fi + 1) begin
        if (ev_used[fi])
          fault_ff[fi] <= 1'b1;
        else if (rd_fault)
          fault_ff[fi] <= 1'b0;
      end
    end
  end

  // Self-protection trips
  wire core_trip = ev_used[`SCFC_FLT_CORE_OV];
  wire ana_trip = ev_used[`SCFC_FLT_ANA_OV] || ev_used[`SCFC_FLT_ANA_OC];
  wire aux_trip = ev_used[`SCFC_FLT_AUX_OV] || ev_used[`SCFC_FLT_AUX_OC];

  // Regulator enables
  reg [4:0] nxt_en;
  always @* begin
    nxt_en = reg_enable;
    if (wr_ctrl) begin
      nxt_en[`SCFC_EN_CORE] = pwdata[`SCFC_EN_CORE];
      nxt_en[`SCFC_EN_ANA] = pwdata[`SCFC_EN_ANA];
      nxt_en[`SCFC_EN_AUX] = pwdata[`SCFC_EN_AUX];
    end
    if (core_trip) begin
      nxt_en[`SCFC_EN_CORE] = 1'b0;
    end
    if (ana_trip) begin
      nxt_en[`SCFC_EN_ANA] = 1'b0;
    end
    if (aux_trip) begin
      nxt_en[`SCFC_EN_AUX] = 1'b0;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      reg_enable <= `SCFC_EN_RESET;
    end else begin
      reg_enable <= nxt_en;
    end
  end

  // Interrupt config: bit0 enable, bit1 long pulse
  reg [1:0] intcfg_ff;
  always @(posedge clk) begin
    if (reset)
      intcfg_ff <= `SCFC_INTCFG_RESET;
    else if (wr_int) begin
      intcfg_ff[0] <= pwdata[0];
      intcfg_ff[1] <= pwdata[1];
    end
  end

  // Interrupt pulse generator
  reg [CNT_W-1:0] pulse_cnt_ff;
  reg pend_ff;
  reg [CNT_W-1:0] nxt_len;
  wire ev_any = |ev_used;
  wire irq_req = ev_any && intcfg_ff[0];
  wire pulse_busy = (pulse_cnt_ff != {CNT_W{1'b0}});
  wire pulse_last = (pulse_cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});
  always @* begin
    if (intcfg_ff[1])
      nxt_len = LONG_CYCLES[CNT_W-1:0];
    else
      nxt_len = SHORT_CYCLES[CNT_W-1:0];
  end
  always @(posedge clk) begin
    if (reset) begin
      pulse_cnt_ff <= {CNT_W{1'b0}};
      pend_ff <= 1'b0;
      interrupt_pulse_n <= 1'b1;
    end else if (pulse_busy) begin
      pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
      if (irq_req)
        pend_ff <= 1'b1;
      if (pulse_last)
        interrupt_pulse_n <= 1'b1;
    end else if (interrupt_pulse_n && (irq_req || pend_ff)) begin
      pend_ff <= 1'b0;
      interrupt_pulse_n <= 1'b0;
      pulse_cnt_ff <= nxt_len;
    end
  end

  // APB slave, one wait-free access phase
  reg [31:0] nxt_rdata;
  // Readback word of the decoded configuration
  wire [4:0] stat_word = {buck_boost, deep_fs_safe, deep_fs_main, aux_high, ana_high};

  function reg_hit;
    input [`SCFC_ADDR_W-1:0] a;
    begin
      case (a)
        `SCFC_REG_CTRL: reg_hit = 1'b1;
        `SCFC_REG_STAT: reg_hit = 1'b1;
        `SCFC_REG_FAULT: reg_hit = 1'b1;
        `SCFC_REG_CFG: reg_hit = 1'b1;
        `SCFC_REG_INTCFG: reg_hit = 1'b1;
        default: reg_hit = 1'b0;
      endcase
    end
  endfunction
  always @* begin
    case (paddr)
      `SCFC_REG_CTRL: nxt_rdata = {27'h0, reg_enable};
      `SCFC_REG_STAT: nxt_rdata = {27'h0, stat_word};
      `SCFC_REG_FAULT: nxt_rdata = {26'h0, fault_ff};
      `SCFC_REG_CFG: nxt_rdata = {31'h0, init_phase};
      `SCFC_REG_INTCFG: nxt_rdata = {30'h0, intcfg_ff};
      default: nxt_rdata = 32'h00000000;
    endcase
  end
  wire mapped = reg_hit(paddr);
  always @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? nxt_rdata : 32'h00000000;
    end
  end
endmodule

//--- bench/scfc_asserts.sv
`timescale 1ns/100ps
module scfc_asserts #(parameter LONG_CYCLES = 8, parameter SHORT_CYCLES = 4) (
  input wire clk, input wire reset, input wire wake_low_power_off_state, input wire [2:0] select_strap,
  input wire ext_pass_transistor, input wire core_ov, input wire ana_oc, input wire aux_ov,
  input wire aux_oc, input wire [4:0] reg_enable, input wire deep_fs_main, input wire deep_fs_safe,
  input wire interrupt_pulse_n
);
  localparam int LO = SHORT_CYCLES;
  localparam int HI = LONG_CYCLES + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_reset_enable: assert property ($fell(reset) |-> reg_enable == 5'h1F) else $error("enables");
  chk_core_off: assert property ($rose(core_ov) |-> ##[1:4] !reg_enable[1]) else $error("core on");
  chk_ana_off: assert property ($rose(ana_oc) && ext_pass_transistor |-> ##[1:4] !reg_enable[2])
    else $error("ana on");
  chk_aux_off: assert property ($rose(aux_ov | aux_oc) |-> ##[1:4] !reg_enable[3]) else $error("aux on");
  chk_pulse_min: assert property ($fell(interrupt_pulse_n) |-> !interrupt_pulse_n [*4]) else $error("pulse");
  chk_pulse_end: assert property ($fell(interrupt_pulse_n) |-> ##[LO:HI] interrupt_pulse_n)
    else $error("pulse end");
  chk_fs_agree: assert property (deep_fs_main == deep_fs_safe) else $error("fs differ");
  chk_gnd_strap: assert property ($rose(wake_low_power_off_state) && select_strap == 3'h5 |-> ##[2:6] deep_fs_main)
    else $error("fs off");
endmodule

//--- bench/scfc_host.sv
`timescale 1ns/100ps
module scfc_host (
  input wire clk, input wire pready, input wire pslverr, input wire [31:0] prdata,
  output reg psel, output reg penable, output reg pwrite, output reg [11:0] paddr, output reg [31:0] pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = 0;
  // One APB transfer; released lines are scrambled
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r, output e);
    begin
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
    end
  endtask
endmodule

//--- bench/tb_top.sv
`timescale 1ns/100ps
`include "scfc_defs.vh"
module tb_top;
  reg clk = 0, reset = 1, wake_low_power_off_state = 0, init_phase = 1, low_side_gate_pin = 0, ext_pass_transistor = 1;
  reg [2:0] select_strap = 3'h4;
  reg [5:0] flt = 0;
  reg [31:0] rd, v;
  reg [4:0] e;
  reg er;
  integer fails = 0, checks = 0, seed = 32'hd037, cyc = 0, npulse = 0, lowc = 0, width = 0, k;
  wire core_ov = flt[0], ana_ov = flt[1], ana_oc = flt[2], aux_ov = flt[3], aux_oc = flt[4];
  wire battery_sense_low = flt[5];
  wire psel, penable, pwrite, pready, pslverr, ana_high, aux_high, deep_fs_main, deep_fs_safe;
  wire buck_boost, interrupt_pulse_n;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [4:0] reg_enable;
  scfc_supply_ctrl #(.LONG_CYCLES(8), .SHORT_CYCLES(4)) i_scfc_supply_ctrl (.*);
  scfc_host i_scfc_host (.*);
  initial forever #5 clk = ~clk;
  // Pulse width monitor and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (interrupt_pulse_n === 1'b0) lowc <= lowc + 1;
    else if (lowc != 0) begin
      width <= lowc;
      npulse <= npulse + 1;
      lowc <= 0;
    end
    if (cyc == 20000) begin
      fails = fails + 1;
      conclude;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task rw(input w, input [11:0] a, input [31:0] d);
    i_scfc_host.xfer(w, a, d, rd, er);
  endtask
  task ev(input integer b);
    begin
      flt[b] <= 1'b1;
      repeat (20) @(posedge clk);
      flt[b] <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  function [4:0] stat(input [2:0] c, input g);
    stat = {g, c == `SCFC_SEL_GND, c == `SCFC_SEL_GND, c == 3'h1 || c == 3'h2, c == 3'h1 || c == 3'h3};
  endfunction
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    chk(reg_enable, 5'h1F, "enable");
    chk({buck_boost, deep_fs_safe, deep_fs_main, aux_high, ana_high}, 5'h00, "open");
    for (k = 0; k < 7; k = k + 1) begin
      select_strap <= k[2:0];
      low_side_gate_pin <= $random(seed);
      wake_low_power_off_state <= 1'b1;
      repeat (6) @(posedge clk);
      wake_low_power_off_state <= 1'b0;
      rw(0, `SCFC_REG_STAT, 0);
      chk(rd[4:0], stat(k[2:0], low_side_gate_pin), "stat");
    end
    select_strap <= 3'h1;
    rw(0, `SCFC_REG_STAT, 0);
    chk(rd[4:0], stat(3'h6, low_side_gate_pin), "held");
    for (k = 0; k < 4; k = k + 1) begin
      v = (k == 0) ? 0 : $random(seed);
      rw(1, `SCFC_REG_CTRL, v);
      @(posedge clk);
      chk(reg_enable, {1'b1, v[3:1], 1'b1}, "ctrl");
    end
    for (k = 0; k < 6; k = k + 1) begin
      rw(1, `SCFC_REG_CTRL, 32'h1F);
      v = npulse;
      e = (k == 5) ? 5'h1F : 5'h1F & ~(5'h1 << (k == 0 ? 1 : k < 3 ? 2 : 3));
      ev(k);
      chk(reg_enable, e, "fault_off");
      chk(npulse, v + 1, "irq");
      chk(width, 8, "long");
      rw(0, `SCFC_REG_FAULT, 0);
      chk(rd, 32'h1 << k, "flag");
      rw(0, `SCFC_REG_FAULT, 0);
      chk({rd[26:0], reg_enable}, e, "cleared");
    end
    ext_pass_transistor <= 1'b0;
    v = npulse;
    ev(2);
    chk(reg_enable, 5'h1F, "no_pass");
    chk(npulse, v, "no_pass_irq");
    rw(0, `SCFC_REG_FAULT, 0);
    chk(rd, 0, "no_pass_flag");
    ext_pass_transistor <= 1'b1;
    rw(1, `SCFC_REG_INTCFG, 32'h1);
    init_phase <= 1'b0;
    rw(1, `SCFC_REG_INTCFG, 32'h3);
    ev(5);
    chk(width, 4, "short");
    init_phase <= 1'b1;
    rw(1, `SCFC_REG_INTCFG, 32'h0);
    v = npulse;
    ev(5);
    chk(npulse, v, "masked");
    rw(0, 12'h014, 0);
    chk({rd[30:0], er}, 1, "unmapped");
    conclude;
  end
endmodule
bind scfc_supply_ctrl scfc_asserts #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) i_scfc_asserts (.*);
